// File: verilog/sep_eeprom_pins.sv
// Serial memory pin front end with its command FIFO and storage array.
`timescale 1ns/1ns
`default_nettype none

module sep_cmd_fifo #(
  parameter int unsigned WIDTH = 27,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr_r;
  logic [PW:0]      rdPtr_r;
  logic             full;
  logic             empty;

  assign empty    = (wrPtr_r == rdPtr_r);
  assign full     = (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]) && (wrPtr_r[PW] != rdPtr_r[PW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = store[rdPtr_r[PW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (inValid && !full)
      store[wrPtr_r[PW-1:0]] <= inData;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      if (inValid && !full)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (outReady && !empty)
        rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule

// Summary of operation
// - Select high means selected; communication only happens while selected.
// - With select low, clock and input transitions are ignored, output silent.
// - Select rising edge returns the frame machine to idle.
// - Select falling edge after a complete write-type frame launches programming while writes are enabled.
// - Select must stay low the minimum deselect interval, or the next frame is ignored.
// - Serial input is sampled on each serial clock rising edge while selected.
// - Serial output data changes only after a serial clock rising edge; status follows busy.
// - Serial output driven only while selected, released when deselected.
// - Frame: first one bit, 2-bit opcode, 8-bit address, 16 data bits, MSB first.
// - Opcodes read, write, erase; extended group decoded by two upper address bits.
// - Read outputs one zero bit, then sixteen stored bits MSB first.
// - After launch, reselect shows status: low busy, high ready, no clock needed.
module sep_eeprom_pins
  import sep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = sep_pkg::PROG_DURATION_CYC
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic selectLine,
  input  wire logic serialClockIn,
  input  wire logic serialInLine,
  output logic      serialOut,
  output logic      serialOutEn_n,
  output logic      busy
);
  import sep_pkg::*;

  logic [2:0]        selSync_r;
  logic [2:0]        sckSync_r;
  logic [2:0]        dinSync_r;
  logic              sel_r;
  logic              sck_r;
  logic              din_r;
  logic              selPrev_r;
  logic              sckPrev_r;
  logic              selRise;
  logic              selFall;
  logic              sckRise;
  sep_frame_e        state_r;
  logic [CNT_W-1:0]  bitCnt_r;
  logic [OPC_W-1:0]  opc_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [ADDR_W-1:0] fullAddr;
  logic [KIND_W-1:0] pend_r;
  logic [DESEL_W-1:0] deselCnt_r;
  logic              armed_r;
  logic              writeEn_r;
  logic              statusMode_r;
  logic              outBit_r;
  logic [DATA_W-1:0] rdShift_r;
  logic              readLoad;
  logic              pushValid;
  logic              pushReady;
  logic              popValid;
  logic              popReady;
  logic [CMD_W-1:0]  popData;
  logic [PROG_W-1:0] progCnt_r;
  logic [DATA_W-1:0] mem [1 << ADDR_W];

  function automatic logic isProg(input logic [KIND_W-1:0] k);
    isProg = (k == KIND_WRITE) || (k == KIND_PROG_ALL) || (k == KIND_ERASE)
             || (k == KIND_ERASE_ALL);
  endfunction

  // Pins change when the second and third stages agree; the first stage feeds only the second.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      selSync_r <= 3'h0;
      sckSync_r <= 3'h0;
      dinSync_r <= 3'h0;
      sel_r     <= 1'b0;
      sck_r     <= 1'b0;
      din_r     <= 1'b0;
      selPrev_r <= 1'b0;
      sckPrev_r <= 1'b0;
    end
    else
    begin
      selSync_r <= {selSync_r[1:0], selectLine};
      sckSync_r <= {sckSync_r[1:0], serialClockIn};
      dinSync_r <= {dinSync_r[1:0], serialInLine};
      if (selSync_r[1] == selSync_r[2])
        sel_r <= selSync_r[2];
      if (sckSync_r[1] == sckSync_r[2])
        sck_r <= sckSync_r[2];
      if (dinSync_r[1] == dinSync_r[2])
        din_r <= dinSync_r[2];
      selPrev_r <= sel_r;
      sckPrev_r <= sck_r;
    end
  end

  assign selRise  = sel_r && !selPrev_r;
  assign selFall  = !sel_r && selPrev_r;
  assign sckRise  = sel_r && sck_r && !sckPrev_r;
  assign fullAddr = {addr_r[ADDR_W-2:0], din_r};
  assign readLoad = sckRise && (state_r == FR_ADDR) && (bitCnt_r == ADDR_LAST)
                    && (opc_r == OPC_READ);
  assign busy     = (progCnt_r != '0) || popValid;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      deselCnt_r <= DESEL_W'(MIN_DESELECT_CYC);
      armed_r    <= 1'b0;
    end
    else
    begin
      if (sel_r)
        deselCnt_r <= '0;
      else if (deselCnt_r != DESEL_W'(MIN_DESELECT_CYC))
        deselCnt_r <= deselCnt_r + 1'b1;
      if (selRise)
        armed_r <= (deselCnt_r == DESEL_W'(MIN_DESELECT_CYC));
    end
  end

  // Frame receiver; a short deselect leaves the next frame unarmed and it is ignored.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r  <= FR_IDLE;
      bitCnt_r <= '0;
      opc_r    <= '0;
      addr_r   <= '0;
      data_r   <= '0;
      pend_r   <= KIND_NONE;
    end
    else if (!sel_r || selRise)
    begin
      state_r  <= FR_IDLE;
      bitCnt_r <= '0;
      if (selRise)
        pend_r <= KIND_NONE;
    end
    else if (sckRise)
    begin
      bitCnt_r <= bitCnt_r + 1'b1;
      unique case (state_r)
        FR_IDLE:
        begin
          bitCnt_r <= '0;
          if (din_r && armed_r && !busy)
            state_r <= FR_OPC;
        end
        FR_OPC:
        begin
          opc_r <= {opc_r[0], din_r};
          if (bitCnt_r == OPC_LAST)
          begin
            state_r  <= FR_ADDR;
            bitCnt_r <= '0;
          end
        end
        FR_ADDR:
        begin
          addr_r <= fullAddr;
          if (bitCnt_r == ADDR_LAST)
          begin
            bitCnt_r <= '0;
            state_r  <= FR_DONE;
            unique case (opc_r)
              OPC_READ:  state_r <= FR_RD;
              OPC_WRITE: state_r <= FR_DATA;
              OPC_ERASE: pend_r  <= KIND_ERASE;
              OPC_EXT:
              begin
                unique case (addr_r[ADDR_W-2 -: 2])
                  EXT_ENABLE:    pend_r <= KIND_WEN;
                  EXT_DISABLE:   pend_r <= KIND_DISABLE;
                  EXT_ERASE_ALL: pend_r <= KIND_ERASE_ALL;
                  EXT_PROG_ALL:  state_r <= FR_DATA;
                endcase
              end
            endcase
          end
        end
        FR_DATA:
        begin
          data_r <= {data_r[DATA_W-2:0], din_r};
          if (bitCnt_r == DATA_LAST)
          begin
            state_r <= FR_DONE;
            pend_r  <= (opc_r == OPC_WRITE) ? KIND_WRITE : KIND_PROG_ALL;
          end
        end
        FR_RD:
        begin
          if (bitCnt_r == DATA_LAST)
            state_r <= FR_DONE;
        end
        FR_DONE:
          bitCnt_r <= bitCnt_r;
      endcase
    end
  end

  // Enable latch changes at the end of the frame, not when the bits arrive.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      writeEn_r <= 1'b0;
    else if (selFall && (pend_r == KIND_WEN))
      writeEn_r <= 1'b1;
    else if (selFall && (pend_r == KIND_DISABLE))
      writeEn_r <= 1'b0;
  end

  assign pushValid = selFall && isProg(pend_r) && writeEn_r;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      statusMode_r <= 1'b0;
    else if (pushValid && pushReady)
      statusMode_r <= 1'b1;
    else if (sckRise && (state_r == FR_IDLE) && din_r && armed_r && !busy)
      statusMode_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      outBit_r  <= 1'b0;
      rdShift_r <= '0;
    end
    else if (!sel_r)
      outBit_r <= 1'b0;
    else if (readLoad)
    begin
      outBit_r  <= 1'b0;
      rdShift_r <= mem[fullAddr];
    end
    else if (sckRise && (state_r == FR_RD))
    begin
      outBit_r  <= rdShift_r[DATA_W-1];
      rdShift_r <= {rdShift_r[DATA_W-2:0], 1'b0};
    end
    else if (statusMode_r && (state_r == FR_IDLE))
      outBit_r <= !busy;
  end

  assign serialOut     = outBit_r;
  assign serialOutEn_n = !sel_r;

  // Launched commands queue here so the array engine can stall the receiver.
  sep_cmd_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({pend_r, addr_r, data_r}),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popData)
  );

  assign popReady = (progCnt_r == '0);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      progCnt_r <= '0;
    else if (popValid && popReady)
      progCnt_r <= PROG_W'(PROG_CYCLES);
    else if (progCnt_r != '0)
      progCnt_r <= progCnt_r - 1'b1;
  end

  // The array is written at launch; only the ready status waits for the timer.
  always_ff @(posedge ref_clk)
  begin
    if (popValid && popReady)
    begin
      for (int i = 0; i < (1 << ADDR_W); i++)
      begin
        if (popData[CMD_W-1 -: KIND_W] == KIND_PROG_ALL)
          mem[i] <= popData[DATA_W-1:0];
        else if (popData[CMD_W-1 -: KIND_W] == KIND_ERASE_ALL)
          mem[i] <= ERASED_WORD;
      end
      if (popData[CMD_W-1 -: KIND_W] == KIND_WRITE)
        mem[popData[DATA_W +: ADDR_W]] <= popData[DATA_W-1:0];
      else if (popData[CMD_W-1 -: KIND_W] == KIND_ERASE)
        mem[popData[DATA_W +: ADDR_W]] <= ERASED_WORD;
    end
  end
endmodule

`default_nettype wire

// File: verilog/sep_pkg.sv
// Package with the constants, codes and states of the serial memory pin front end.
package sep_pkg;

  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned OPC_W        = 2;
  localparam int unsigned KIND_W       = 3;
  localparam int unsigned CMD_W        = KIND_W + ADDR_W + DATA_W;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned FIFO_DEPTH   = 16;

  // Opcodes of the frame and the upper address bits of the extended group.
  localparam logic [1:0] OPC_EXT       = 2'h0;
  localparam logic [1:0] OPC_WRITE     = 2'h1;
  localparam logic [1:0] OPC_READ      = 2'h2;
  localparam logic [1:0] OPC_ERASE     = 2'h3;
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_PROG_ALL  = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;

  // Kinds of a completed frame.
  localparam logic [2:0] KIND_NONE     = 3'h0;
  localparam logic [2:0] KIND_WRITE    = 3'h1;
  localparam logic [2:0] KIND_PROG_ALL = 3'h2;
  localparam logic [2:0] KIND_ERASE    = 3'h3;
  localparam logic [2:0] KIND_ERASE_ALL = 3'h4;
  localparam logic [2:0] KIND_WEN      = 3'h5;
  localparam logic [2:0] KIND_DISABLE  = 3'h6;

  localparam logic [4:0] OPC_LAST      = 5'h01;
  localparam logic [4:0] ADDR_LAST     = 5'h07;
  localparam logic [4:0] DATA_LAST     = 5'h0F;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

  // Timing at a 100 MHz reference clock.
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned MIN_DESELECT_NS      = 1000;
  localparam int unsigned PROG_DURATION_MS     = 15;
  localparam int unsigned MIN_DESELECT_CYC     =
    (MIN_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_DURATION_CYC    =
    (PROG_DURATION_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned DESEL_W              = 8;
  localparam int unsigned PROG_W               = 24;

  typedef enum logic [5:0] {
    FR_IDLE = 6'h01,
    FR_OPC  = 6'h02,
    FR_ADDR = 6'h04,
    FR_DATA = 6'h08,
    FR_RD   = 6'h10,
    FR_DONE = 6'h20
  } sep_frame_e;

endpackage

// File: tb/sep_eeprom_pins_chk.sv
// Checker of the serial memory pin front end.
`timescale 1ns/1ns
`default_nettype none
module sep_eeprom_pins_chk #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic selectLine,
  input wire logic serialClockIn,
  input wire logic serialInLine,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  input wire logic busy
);
  logic        clkPrev_r;
  logic [3:0]  sinceClk_r;
  logic [31:0] busyCnt_r;
  // Cycles since the last pin clock rise are counted, since the design output lags it by its filter.
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      clkPrev_r <= 1'b0;
      sinceClk_r <= 4'hF;
      busyCnt_r <= 32'h0;
    end
    else
    begin
      clkPrev_r <= serialClockIn;
      busyCnt_r <= busy ? busyCnt_r + 32'h1 : 32'h0;
      if (serialClockIn && !clkPrev_r)
        sinceClk_r <= 4'h0;
      else if (sinceClk_r != 4'hF)
        sinceClk_r <= sinceClk_r + 4'h1;
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |-> serialOutEn_n && !serialOut && !busy) else $error("outputs active in reset");
  a_sel_drives: assert property (selectLine [*6] |-> !serialOutEn_n)
    else $error("output not driven while selected");
  a_desel_release: assert property (!selectLine [*6] |-> serialOutEn_n && !serialOut)
    else $error("output active while deselected");
  a_out_on_clk: assert property ($changed(serialOut) && !serialOutEn_n
    && !$past(serialOutEn_n, 3) && !$past(busy) && !$past(busy, 2) |-> sinceClk_r <= 4'h8)
    else $error("output changed without a clock rise");
  a_status_busy: assert property (busy && !serialOutEn_n && !$past(serialOutEn_n, 3)
    |-> !serialOut) else $error("status not low while busy");
  a_ready_high: assert property ($fell(busy) && !serialOutEn_n |-> ##[0:2] serialOut)
    else $error("status not high when ready");
  a_prog_len: assert property ($fell(busy) |-> busyCnt_r >= PROG_CYCLES
    && busyCnt_r <= PROG_CYCLES + 4) else $error("programming length wrong");
  a_launch_desel: assert property ($rose(busy) |-> !selectLine && !$past(selectLine, 3))
    else $error("programming launched while selected");
  cover property ($rose(busy));
  cover property ($fell(busy) && !serialOutEn_n);
  cover property (!serialOutEn_n && $rose(serialClockIn));
endmodule
`default_nettype wire

// File: tb/sep_master_model.sv
// Serial bus master model that drives the select, clock and data pins.
`timescale 1ns/1ns
`default_nettype none
module sep_master_model (
  input  wire logic ref_clk,
  input  wire logic serialOut,
  input  wire logic serialOutEn_n,
  output logic      selectLine,
  output logic      serialClockIn,
  output logic      serialInLine
);
  localparam int HALF = 8;
  logic doPin;
  // A released output floats to its pull-up level, so a leak shows as data.
  assign doPin = serialOutEn_n ? 1'b1 : serialOut;
  initial
  begin
    selectLine = 1'b0;
    serialClockIn = 1'b0;
    serialInLine = 1'b0;
  end
  task automatic setSel(input logic v);
    @(negedge ref_clk);
    selectLine = v;
    if (!v)
      serialInLine = ~serialInLine;
    repeat (v ? 8 : 110) @(negedge ref_clk);
  endtask
  task automatic shortLow();
    @(negedge ref_clk);
    selectLine = 1'b0;
    repeat (20) @(negedge ref_clk);
    selectLine = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
  // one bit per clock, sampled after the rise
  task automatic shiftBits(input logic [31:0] v, input int n, output logic [15:0] q);
    q = 16'h0000;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialInLine = v[i];
      repeat (HALF) @(negedge ref_clk);
      serialClockIn = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      q = {q[14:0], doPin};
      serialClockIn = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_serial_eeprom_pin_interface.sv
// Testbench of the serial memory pin front end.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_eeprom_pin_interface;
  import sep_pkg::*;
  localparam int PROG = 400;
  logic ref_clk;
  logic sys_rst;
  logic selectLine;
  logic serialClockIn;
  logic serialInLine;
  logic serialOut;
  logic serialOutEn_n;
  logic busy;
  int   num_errors = 0;
  int   n_compared = 0;
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  sep_eeprom_pins #(.PROG_CYCLES(PROG)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .selectLine(selectLine),
    .serialClockIn(serialClockIn), .serialInLine(serialInLine), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .busy(busy));
  sep_master_model mst_u (
    .ref_clk(ref_clk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
    .selectLine(selectLine),
    .serialClockIn(serialClockIn), .serialInLine(serialInLine));
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [31:0] v, input int n);
    logic [15:0] q;
    mst_u.setSel(1'b1);
    mst_u.shiftBits(v, n, q);
    mst_u.setSel(1'b0);
  endtask
  // Two leading zeros must be skipped before the start bit.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    mst_u.setSel(1'b1);
    mst_u.shiftBits({19'h0, 3'b001, OPC_READ, a}, 13, q);
    chk({15'h0, q[0]}, 16'h0000);
    mst_u.shiftBits(32'h0, 16, q);
    chk(q, exp);
    mst_u.setSel(1'b0);
  endtask
  task automatic prog(input logic [31:0] v, input int n);
    frame(v, n);
    mst_u.setSel(1'b1);
    chk({14'h0, busy, serialOut}, 16'h0002);
    repeat (PROG + 20) @(negedge ref_clk);
    chk({14'h0, busy, serialOut}, 16'h0001);
    mst_u.setSel(1'b0);
  endtask
  task automatic t_write();
    frame({21'h0, 1'b1, OPC_EXT, EXT_ENABLE, 6'h00}, 11);
    prog({5'h0, 1'b1, OPC_WRITE, 8'h00, 16'hA5C3}, 27);
    prog({5'h0, 1'b1, OPC_WRITE, 8'hFF, 16'h5A3C}, 27);
    rd(8'h00, 16'hA5C3);
    rd(8'hFF, 16'h5A3C);
  endtask
  task automatic t_erase();
    prog({21'h0, 1'b1, OPC_ERASE, 8'hFF}, 11);
    rd(8'hFF, 16'hFFFF);
    rd(8'h00, 16'hA5C3);
  endtask
  task automatic t_all();
    prog({5'h0, 1'b1, OPC_EXT, EXT_PROG_ALL, 6'h00, 16'h1234}, 27);
    rd(8'h7F, 16'h1234);
    prog({21'h0, 1'b1, OPC_EXT, EXT_ERASE_ALL, 6'h00}, 11);
    rd(8'h33, 16'hFFFF);
  endtask
  // Deselected traffic, an abandoned frame and a write while disabled.
  task automatic t_guard();
    logic [15:0] q;
    mst_u.shiftBits(32'hFFFF_FFFF, 8, q);
    chk(q, 16'h00FF);
    chk({15'h0, serialOutEn_n}, 16'h0001);
    mst_u.setSel(1'b1);
    mst_u.shiftBits({29'h0, 1'b1, OPC_WRITE}, 3, q);
    mst_u.setSel(1'b0);
    frame({21'h0, 1'b1, OPC_EXT, EXT_DISABLE, 6'h00}, 11);
    frame({5'h0, 1'b1, OPC_WRITE, 8'h10, 16'hBEEF}, 27);
    chk({15'h0, busy}, 16'h0000);
    rd(8'h10, 16'hFFFF);
  endtask
  // A frame after a short deselect, and one sent while busy, are both refused.
  task automatic t_refuse();
    logic [15:0] q;
    frame({21'h0, 1'b1, OPC_EXT, EXT_ENABLE, 6'h00}, 11);
    mst_u.setSel(1'b1);
    mst_u.shortLow();
    mst_u.shiftBits({5'h0, 1'b1, OPC_WRITE, 8'h20, 16'h0F0F}, 27, q);
    mst_u.setSel(1'b0);
    chk({15'h0, busy}, 16'h0000);
    rd(8'h20, 16'hFFFF);
    frame({5'h0, 1'b1, OPC_WRITE, 8'h21, 16'h1111}, 27);
    frame({5'h0, 1'b1, OPC_WRITE, 8'h22, 16'h0000}, 27);
    chk({15'h0, busy}, 16'h0000);
    rd(8'h22, 16'hFFFF);
    rd(8'h21, 16'h1111);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_write();
    t_erase();
    t_all();
    t_guard();
    t_refuse();
    end_of_test();
  end
  // The tests need about 15000 cycles; this limit leaves wide margin.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end
endmodule
bind sep_eeprom_pins sep_eeprom_pins_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .selectLine(selectLine),
  .serialClockIn(serialClockIn), .serialInLine(serialInLine), .serialOut(serialOut),
  .serialOutEn_n(serialOutEn_n), .busy(busy));
`default_nettype wire
